//--- eeprom_pkg.sv
// Shared constants for the serial EEPROM command and status logic.
// Assumes a byte-wide store and an eight-bit instruction set.
`default_nettype none

package eeprom_pkg;

	// ----------------------------------------------------------------
	// Instruction codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_STATUS_WRITE_CMD  = 8'h01;
	localparam logic [7:0] OP_WRITE             = 8'h02;
	localparam logic [7:0] OP_READ              = 8'h03;
	localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
	localparam logic [7:0] OP_STATUS_READ_CMD   = 8'h05;
	localparam logic [7:0] OP_WRITE_ENABLE_CMD  = 8'h06;

	// ----------------------------------------------------------------
	// Serial clock counts that mark field ends
	// ----------------------------------------------------------------
	localparam int CNT_W = 16;
	typedef logic [CNT_W-1:0] bitcnt_t;
	localparam bitcnt_t CNT_OPCODE  = 16'h0008;
	localparam bitcnt_t CNT_STATUS  = 16'h0010;
	localparam bitcnt_t CNT_ADDR    = 16'h0018;
	localparam bitcnt_t CNT_DATA1   = 16'h0020;
	localparam bitcnt_t PAGE_BYTES  = 16'h0020;
	localparam int      PAGE_AW     = 5;

	// ----------------------------------------------------------------
	// Status register layout and reset values
	// ----------------------------------------------------------------
	localparam int SR_DISABLE_BIT = 7;
	localparam int SR_BP_HI_BIT   = 3;
	localparam int SR_BP_LO_BIT   = 2;
	localparam int SR_WEL_BIT     = 1;
	localparam int SR_WIP_BIT     = 0;
	localparam logic [2:0] NV_RESET    = 3'h0;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int WRITE_TIME_US = 5000;
	localparam int CLK_MHZ       = 125;
	localparam int PROG_CYCLES_DFLT = WRITE_TIME_US * CLK_MHZ;
	localparam int SYNC_STAGES   = 3;

	typedef enum logic [1:0] {ST_IDLE, ST_COPY, ST_PROG} wr_state_t;

endpackage : eeprom_pkg

`default_nettype wire

//--- ram_port_if.sv
// Port bundle of a two-clock byte store.
// Assumes the write and read sides belong to one owner module.
`timescale 1ns/1ps
`default_nettype none

interface ram_port_if #(
	parameter int AW = 12,
	parameter int DW = 8
);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic          re;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;

	modport store (input we, waddr, wdata, re, raddr, output rdata);
	modport user  (output we, waddr, wdata, re, raddr, input rdata);
endinterface : ram_port_if

`default_nettype wire

//--- level_sync.sv
// Chain of flip-flops that brings a level into a clock domain.
// Assumes the consumer reads only the last two stages.
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
	parameter int W      = 1,
	parameter int STAGES = 3
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q_prev,
	output logic      [W-1:0] q_last
);
	logic [W-1:0] s_q [STAGES];

	// Plain shift chain, no reset needed for a level
	always_ff @(posedge clk) begin
		s_q[0] <= d;
		for (int i = 1; i < STAGES; i++) begin
			s_q[i] <= s_q[i-1];
		end
	end

	assign q_prev = s_q[STAGES-2];
	assign q_last = s_q[STAGES-1];
endmodule : level_sync

`default_nettype wire

//--- byte_store.sv
// Two-clock byte memory with a registered read port.
// Assumes the owner keeps write and read of one word apart in time.
`timescale 1ns/1ps
`default_nettype none

module byte_store #(
	parameter int         AW   = 12,
	parameter int         DW   = 8,
	parameter logic [7:0] INIT = 8'hff
) (
	input  wire logic wr_clk,
	input  wire logic rd_clk,
	ram_port_if.store port
);
	logic [DW-1:0] mem [2**AW];
	logic [DW-1:0] rdata_q;

	// Contents as delivered
	initial begin
		for (int i = 0; i < 2**AW; i++) begin
			mem[i] = DW'(INIT);
		end
	end

	// Write side
	always_ff @(posedge wr_clk) begin
		if (port.we) begin
			mem[port.waddr] <= port.wdata;
		end
	end

	// Read side, data from a register
	always_ff @(posedge rd_clk) begin
		if (port.re) begin
			rdata_q <= mem[port.raddr];
		end
	end

	assign port.rdata = rdata_q;
endmodule : byte_store

`default_nettype wire

//--- spi_eeprom_command_status_logic.sv
// Serial EEPROM front end: link engine on the serial clock, status and
// write sequencing on the core clock.
// Assumes the host stops the serial clock while select is high.
//
// Overview of operation
// - Select high: deselected, output high impedance
// - Deselect goes standby after running write finishes
// - Input bits sampled on rising serial clock
// - Output changes on falling serial clock
// - Pause: output off, clock and input ignored
// - Delivered: bytes all ones, protect bits zero
// - Frame: select falls, opcode byte MSB first
// - Unknown opcode: ignore rest of frame
// - Status read repeats status byte from clock 9
// - Status write takes clocks 9 to 16
// - Memory read: address, then sequential bytes
// - Address bits above array size ignored
// - Disable bit plus protect pin blocks status write
// - Block protect bits shield memory writes
// - Latch set only by enable; gates writes
// - Latch cleared by reset, disable, write end
// - Progress bit high only during internal write
// - Enable/disable need exactly eight clocks
// - Bits 6 to 4 read zero, unchanged
// - No memory read during internal write
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_command_status_logic
	import eeprom_pkg::*;
#(
	parameter int ADDR_W      = 12,
	parameter int PROG_CYCLES = PROG_CYCLES_DFLT
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic sck,
	input  wire logic cs_n,
	input  wire logic si,
	input  wire logic hold_n,
	input  wire logic wp_n,
	output logic      so,
	output logic      so_oe
);
	localparam int TIMER_W = $clog2(PROG_CYCLES + 1);

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic op_known(input logic [7:0] op);
		op_known = (op == OP_WRITE_ENABLE_CMD) || (op == OP_WRITE_DISABLE_CMD) ||
			(op == OP_STATUS_READ_CMD) || (op == OP_STATUS_WRITE_CMD) ||
			(op == OP_READ) || (op == OP_WRITE);
	endfunction : op_known

	// Top quarter, top half or whole array shielded
	function automatic logic is_protected(input logic [1:0] bp,
			input logic [ADDR_W-1:0] a);
		case (bp)
			2'h1:    is_protected = (a[ADDR_W-1 -: 2] == 2'h3);
			2'h2:    is_protected = a[ADDR_W-1];
			2'h3:    is_protected = 1'h1;
			default: is_protected = 1'h0;
		endcase
	endfunction : is_protected

	// ------------------------------------------------------------
	// Stores
	// ------------------------------------------------------------
	ram_port_if #(.AW(ADDR_W),  .DW(8)) arr ();
	ram_port_if #(.AW(PAGE_AW), .DW(8)) pg ();

	byte_store #(.AW(ADDR_W), .DW(8), .INIT(ERASED_BYTE)) u_array (
		.wr_clk (core_clk),
		.rd_clk (sck),
		.port   (arr)
	);

	byte_store #(.AW(PAGE_AW), .DW(8), .INIT(8'h00)) u_page (
		.wr_clk (sck),
		.rd_clk (core_clk),
		.port   (pg)
	);

	// ------------------------------------------------------------
	// Link domain, rising edge: bit counting and capture
	// ------------------------------------------------------------
	logic          started_q;
	logic          started_d;
	logic          dead_q;
	logic          dead_d;
	bitcnt_t       cnt_q;
	bitcnt_t       cnt_d;
	logic [7:0]    shift_q;
	logic [7:0]    shift_d;
	logic [7:0]    op_q;
	logic [7:0]    op_d;
	logic [15:0]   addr_q;
	logic [15:0]   addr_d;
	logic [7:0]    sdata_q;
	logic [7:0]    sdata_d;
	logic [4:0]    pidx_q;
	logic [4:0]    pidx_d;
	logic [15:0]   rptr_q;
	logic [15:0]   rptr_d;
	logic          pg_we;
	logic          arr_re;
	logic [15:0]   arr_raddr;
	logic [7:0]    status_s;
	logic [7:0]    status_q;
	logic          wip_s;

	// Status byte brought onto the serial clock
	level_sync #(.W(8), .STAGES(SYNC_STAGES)) u_sync_status (
		.clk    (sck),
		.d      (status_q),
		.q_prev (),
		.q_last (status_s)
	);

	assign wip_s = status_s[SR_WIP_BIT];

	// Next values of the rising-edge link state
	always_comb begin
		started_d = started_q;
		dead_d    = dead_q;
		cnt_d     = cnt_q;
		shift_d   = shift_q;
		op_d      = op_q;
		addr_d    = addr_q;
		sdata_d   = sdata_q;
		pidx_d    = pidx_q;
		rptr_d    = rptr_q;
		pg_we     = 1'h0;
		arr_re    = 1'h0;
		arr_raddr = rptr_q;
		if (hold_n) begin
			started_d = 1'h1;
			cnt_d     = !started_q ? 16'h0001 :
				(&cnt_q ? cnt_q : cnt_q + 16'h0001);
			shift_d   = {shift_q[6:0], si};
			if (cnt_d == CNT_OPCODE) begin
				op_d = shift_d;
				if (!op_known(shift_d)) begin
					dead_d = 1'h1;
				end
				if (shift_d == OP_READ && wip_s) begin
					dead_d = 1'h1;
				end
			end
			if (cnt_d == CNT_STATUS) begin
				sdata_d       = shift_d;
				addr_d[15:8]  = shift_d;
			end
			if (cnt_d == CNT_ADDR) begin
				addr_d[7:0] = shift_d;
				pidx_d      = shift_d[4:0];
				arr_re      = !dead_q;
				arr_raddr   = addr_d;
				rptr_d      = addr_d + 16'h0001;
			end else if (cnt_d > CNT_ADDR && cnt_d[2:0] == 3'h0 && !dead_q) begin
				if (op_q == OP_READ) begin
					arr_re    = 1'h1;
					arr_raddr = rptr_q;
					rptr_d    = rptr_q + 16'h0001;
				end
				if (op_q == OP_WRITE) begin
					pg_we  = 1'h1;
					pidx_d = pidx_q + 5'h01;
				end
			end
		end
	end

	// Frame flags cleared while deselected
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			started_q <= 1'h0;
			dead_q    <= 1'h0;
		end else begin
			started_q <= started_d;
			dead_q    <= dead_d;
		end
	end

	// Frame results kept after select rises for the core side
	always_ff @(posedge sck) begin
		cnt_q   <= cnt_d;
		shift_q <= shift_d;
		op_q    <= op_d;
		addr_q  <= addr_d;
		sdata_q <= sdata_d;
		pidx_q  <= pidx_d;
		rptr_q  <= rptr_d;
	end

	// Array read and page buffer write, high address bits dropped
	assign arr.re    = arr_re;
	assign arr.raddr = arr_raddr[ADDR_W-1:0];
	assign pg.we     = pg_we;
	assign pg.waddr  = pidx_q;
	assign pg.wdata  = shift_d;

	// ------------------------------------------------------------
	// Link domain, falling edge: output shifter
	// ------------------------------------------------------------
	logic       so_q;
	logic       so_d;
	logic       oe_q;
	logic       oe_d;
	logic [7:0] osh_q;
	logic [7:0] osh_d;
	logic       load_sr;
	logic       load_rd;
	logic [7:0] obyte;

	// Next output bit; no falling edge acts before the first rising one
	always_comb begin
		so_d    = so_q;
		oe_d    = oe_q;
		osh_d   = osh_q;
		load_sr = (op_q == OP_STATUS_READ_CMD) && cnt_q >= CNT_OPCODE &&
			cnt_q[2:0] == 3'h0;
		load_rd = (op_q == OP_READ) && cnt_q >= CNT_ADDR && cnt_q[2:0] == 3'h0;
		obyte   = load_sr ? status_s : arr.rdata;
		if (started_q && hold_n && !dead_q) begin
			if (load_sr || load_rd) begin
				so_d  = obyte[7];
				osh_d = {obyte[6:0], 1'h0};
				oe_d  = 1'h1;
			end else begin
				so_d  = osh_q[7];
				osh_d = {osh_q[6:0], 1'h0};
			end
		end
	end

	// Output changes on the falling edge, and is cleared when select rises
	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			so_q  <= 1'h0;
			oe_q  <= 1'h0;
			osh_q <= 8'h00;
		end else begin
			so_q  <= so_d;
			oe_q  <= oe_d;
			osh_q <= osh_d;
		end
	end

	assign so    = so_q;
	assign so_oe = oe_q & hold_n;

	// ------------------------------------------------------------
	// Core domain: select and protect pin, status, write sequencing
	// ------------------------------------------------------------
	logic [1:0]         pin_prev;
	logic [1:0]         pin_last;
	logic               cs_lvl_q;
	logic               cs_lvl_d;
	logic               wp_lvl_q;
	logic               wp_lvl_d;
	logic               commit;
	wr_state_t          st_q;
	wr_state_t          st_d;
	logic               status_write_disable_q;
	logic               status_write_disable_d;
	logic [1:0]         bp_q;
	logic [1:0]         bp_d;
	logic               wel_q;
	logic               wel_d;
	logic [2:0]         nsr_q;
	logic [2:0]         nsr_d;
	logic               is_sr_q;
	logic               is_sr_d;
	logic [TIMER_W-1:0] timer_q;
	logic [TIMER_W-1:0] timer_d;
	logic [5:0]         idx_q;
	logic [5:0]         idx_d;
	logic [5:0]         ncopy_q;
	logic [5:0]         ncopy_d;
	logic               pend_q;
	logic               pend_d;
	logic [15:0]        waddr_q;
	logic [15:0]        waddr_d;
	logic [7:0]         status_d;
	logic [4:0]         pslot;
	bitcnt_t            m_bytes;

	level_sync #(.W(2), .STAGES(SYNC_STAGES)) u_sync_pins (
		.clk    (core_clk),
		.d      ({cs_n, wp_n}),
		.q_prev (pin_prev),
		.q_last (pin_last)
	);

	assign commit  = cs_lvl_d && !cs_lvl_q;
	assign m_bytes = (cnt_q - CNT_ADDR) >> 3;
	assign pslot   = addr_q[4:0] + idx_q[4:0];

	// Next values of the core state
	always_comb begin
		cs_lvl_d = (pin_prev[1] == pin_last[1]) ? pin_last[1] : cs_lvl_q;
		wp_lvl_d = (pin_prev[0] == pin_last[0]) ? pin_last[0] : wp_lvl_q;
		st_d     = st_q;
		status_write_disable_d   = status_write_disable_q;
		bp_d     = bp_q;
		wel_d    = wel_q;
		nsr_d    = nsr_q;
		is_sr_d  = is_sr_q;
		timer_d  = timer_q;
		idx_d    = idx_q;
		ncopy_d  = ncopy_q;
		pend_d   = 1'h0;
		waddr_d  = waddr_q;
		case (st_q)
			ST_IDLE: begin
				if (commit) begin
					case (op_q)
						OP_WRITE_ENABLE_CMD: begin
							if (cnt_q == CNT_OPCODE) wel_d = 1'h1;
						end
						OP_WRITE_DISABLE_CMD: begin
							if (cnt_q == CNT_OPCODE) wel_d = 1'h0;
						end
						OP_STATUS_WRITE_CMD: begin
							if (cnt_q == CNT_STATUS && wel_q &&
									!(status_write_disable_q && !wp_lvl_q)) begin
								nsr_d   = {sdata_q[SR_DISABLE_BIT],
									sdata_q[SR_BP_HI_BIT:SR_BP_LO_BIT]};
								is_sr_d = 1'h1;
								timer_d = TIMER_W'(PROG_CYCLES);
								st_d    = ST_PROG;
							end
						end
						OP_WRITE: begin
							if (cnt_q >= CNT_DATA1 && cnt_q[2:0] == 3'h0 && wel_q &&
									!is_protected(bp_q, addr_q[ADDR_W-1:0])) begin
								idx_d   = 6'h00;
								ncopy_d = (m_bytes > PAGE_BYTES) ? 6'h20 : m_bytes[5:0];
								is_sr_d = 1'h0;
								st_d    = ST_COPY;
							end
						end
						default: ;
					endcase
				end
			end
			ST_COPY: begin
				pend_d  = 1'h1;
				waddr_d = {addr_q[15:5], pslot};
				idx_d   = idx_q + 6'h01;
				if (idx_d == ncopy_q) begin
					timer_d = TIMER_W'(PROG_CYCLES);
					st_d    = ST_PROG;
				end
			end
			ST_PROG: begin
				// Runs on whatever select does meanwhile
				if (timer_q <= TIMER_W'(1)) begin
					st_d  = ST_IDLE;
					wel_d = 1'h0;
					if (is_sr_q) begin
						{status_write_disable_d, bp_d} = nsr_q;
					end
				end else begin
					timer_d = timer_q - 1'h1;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		status_d = {status_write_disable_d, 3'h0, bp_d, wel_d, st_d != ST_IDLE};
	end

	// Core registers, synchronous reset models power-on
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cs_lvl_q         <= 1'h1;
			wp_lvl_q         <= 1'h1;
			st_q             <= ST_IDLE;
			{status_write_disable_q, bp_q}   <= NV_RESET;
			wel_q            <= 1'h0;
			nsr_q            <= NV_RESET;
			is_sr_q          <= 1'h0;
			timer_q          <= '0;
			idx_q            <= 6'h00;
			ncopy_q          <= 6'h00;
			pend_q           <= 1'h0;
			waddr_q          <= 16'h0000;
			status_q         <= 8'h00;
		end else begin
			cs_lvl_q         <= cs_lvl_d;
			wp_lvl_q         <= wp_lvl_d;
			st_q             <= st_d;
			{status_write_disable_q, bp_q}   <= {status_write_disable_d, bp_d};
			wel_q            <= wel_d;
			nsr_q            <= nsr_d;
			is_sr_q          <= is_sr_d;
			timer_q          <= timer_d;
			idx_q            <= idx_d;
			ncopy_q          <= ncopy_d;
			pend_q           <= pend_d;
			waddr_q          <= waddr_d;
			status_q         <= status_d;
		end
	end

	// Page buffer drained into the array one byte per cycle
	assign pg.re     = (st_q == ST_COPY);
	assign pg.raddr  = pslot;
	assign arr.we    = pend_q;
	assign arr.waddr = waddr_q[ADDR_W-1:0];
	assign arr.wdata = pg.rdata;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_write_enable_cmd_sets;
		@(posedge core_clk) disable iff (!rst_n)
		(commit && st_q == ST_IDLE && op_q == OP_WRITE_ENABLE_CMD && cnt_q == CNT_OPCODE)
			|=> wel_q;
	endproperty
	a_write_enable_cmd_sets: assert property (p_write_enable_cmd_sets) else $error("latch not set");

	property p_write_enable_cmd_count;
		@(posedge core_clk) disable iff (!rst_n)
		(commit && st_q == ST_IDLE && op_q == OP_WRITE_ENABLE_CMD && cnt_q != CNT_OPCODE)
			|=> $stable(wel_q);
	endproperty
	a_write_enable_cmd_count: assert property (p_write_enable_cmd_count) else $error("bad count took");

	property p_write_disable_cmd_clears;
		@(posedge core_clk) disable iff (!rst_n)
		(commit && st_q == ST_IDLE && op_q == OP_WRITE_DISABLE_CMD && cnt_q == CNT_OPCODE)
			|=> !wel_q;
	endproperty
	a_write_disable_cmd_clears: assert property (p_write_disable_cmd_clears) else $error("latch kept");

	property p_need_wel;
		@(posedge core_clk) disable iff (!rst_n)
		(commit && st_q == ST_IDLE && !wel_q &&
			(op_q == OP_WRITE || op_q == OP_STATUS_WRITE_CMD)) |=> st_q == ST_IDLE;
	endproperty
	a_need_wel: assert property (p_need_wel) else $error("write without latch");

	property p_hw_protect;
		@(posedge core_clk) disable iff (!rst_n)
		(commit && st_q == ST_IDLE && op_q == OP_STATUS_WRITE_CMD && status_write_disable_q && !wp_lvl_q)
			|=> (st_q == ST_IDLE) ##1 $stable({status_write_disable_q, bp_q});
	endproperty
	a_hw_protect: assert property (p_hw_protect) else $error("protected write ran");

	property p_done_clears;
		@(posedge core_clk) disable iff (!rst_n)
		(st_q == ST_PROG && timer_q == TIMER_W'(1)) |=> (!wel_q && st_q == ST_IDLE);
	endproperty
	a_done_clears: assert property (p_done_clears) else $error("end left latch");

	property p_nv_hold;
		@(posedge core_clk) disable iff (!rst_n)
		(st_q == ST_PROG && timer_q > TIMER_W'(1)) |=> $stable({status_write_disable_q, bp_q});
	endproperty
	a_nv_hold: assert property (p_nv_hold) else $error("status changed early");

	property p_wip_bit;
		@(posedge core_clk) disable iff (!rst_n)
		1'h1 |=> (status_q[SR_WIP_BIT] == (st_q != ST_IDLE)) && (status_q[6:4] == 3'h0);
	endproperty
	a_wip_bit: assert property (p_wip_bit) else $error("status bits wrong");

	property p_bad_op;
		@(posedge sck) disable iff (cs_n)
		(hold_n && cnt_d == CNT_OPCODE && !op_known(shift_d)) |=> dead_q;
	endproperty
	a_bad_op: assert property (p_bad_op) else $error("unknown code accepted");

	property p_read_busy;
		@(posedge sck) disable iff (cs_n)
		(hold_n && cnt_d == CNT_OPCODE && shift_d == OP_READ && wip_s) |=> dead_q;
	endproperty
	a_read_busy: assert property (p_read_busy) else $error("read while busy");

	property p_dead_quiet;
		@(negedge sck) disable iff (cs_n)
		dead_q |-> !oe_q;
	endproperty
	a_dead_quiet: assert property (p_dead_quiet) else $error("output on after reject");

	c_write_enable_cmd: cover property (@(posedge core_clk) disable iff (!rst_n) commit && wel_d && !wel_q);
	c_sr_prog: cover property (@(posedge core_clk) disable iff (!rst_n)
		st_q == ST_PROG && is_sr_q);
	c_mem_prog: cover property (@(posedge core_clk) disable iff (!rst_n) st_q == ST_COPY);
	c_read_out: cover property (@(negedge sck) disable iff (cs_n) oe_q && op_q == OP_READ);
endmodule : spi_eeprom_command_status_logic

`default_nettype wire

//--- spi_host_model.sv
// Host side of the serial link: select, clock, data and pause.
// Assumes the device samples on rising and shifts on falling clock.
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	output var logic sck,
	output var logic cs_n,
	output var logic si,
	output var logic hold_n,
	input  wire logic so,
	input  wire logic so_oe,
	output var logic oe_seen,
	output var logic hold_oe
);
	// ------------------------------------------------------------
	// Idle levels; clock stands still outside frames
	// ------------------------------------------------------------
	initial begin
		sck = 1'b0;
		cs_n = 1'b0;
		si = 1'b0;
		hold_n = 1'b1;
		oe_seen = 1'b0;
		hold_oe = 1'b0;
		// A clean rising select edge clears the link frame state at start-up
		#1;
		cs_n = 1'b1;
	end

	// ------------------------------------------------------------
	// One frame, MSB first, with an optional pause
	// ------------------------------------------------------------
	task automatic frame(input logic [63:0] tx, input int nbits, input bit mode3,
			input int hold_at, output logic [63:0] rx);
		rx = '0;
		oe_seen = 1'b0;
		sck = mode3;
		#7;
		cs_n = 1'b0;
		#16;
		for (int i = 0; i < nbits; i++) begin
			sck = 1'b0;
			si = tx[63-i];
			if (i == hold_at) begin
				#8;
				hold_n = 1'b0;
				#8;
				sck = 1'b1;
				si = ~si;
				#16;
				sck = 1'b0;
				#8;
				hold_oe = so_oe;
				hold_n = 1'b1;
				si = tx[63-i];
			end
			#16;
			sck = 1'b1;
			rx = {rx[62:0], so};
			oe_seen = oe_seen | so_oe;
			#16;
		end
		sck = mode3;
		#16;
		cs_n = 1'b1;
		si = ~si; // Released line shows no stale value
		#100;
	endtask : frame
endmodule : spi_host_model

`default_nettype wire

//--- spi_eeprom_command_status_logic_tb_top.sv
// Self-checking bench for the serial EEPROM front end.
// Assumes the host model and the package are compiled first.
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_command_status_logic_tb_top;
	import eeprom_pkg::*;
	localparam int PROG = 400;
	logic        core_clk, rst_n, wp_n, sck, cs_n, si, hold_n;
	logic        so, so_oe, oe_seen, hold_oe;
	int          failures;
	int          compares;
	bit          mode3;
	logic [63:0] rx;

	// ------------------------------------------------------------
	// Design, host and clock
	// ------------------------------------------------------------
	spi_eeprom_command_status_logic #(.ADDR_W(12), .PROG_CYCLES(PROG))
		spi_eeprom_command_status_logic_inst (.core_clk(core_clk), .rst_n(rst_n),
		.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
		.so(so), .so_oe(so_oe));
	spi_host_model spi_host_model_inst (.sck(sck), .cs_n(cs_n), .si(si),
		.hold_n(hold_n), .so(so), .so_oe(so_oe), .oe_seen(oe_seen), .hold_oe(hold_oe));
	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic test_done();
		if (failures == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic xfer(input logic [63:0] tx, input int n, input int hold_at = -1);
		spi_host_model_inst.frame(tx, n, mode3, hold_at, rx);
		mode3 = ~mode3;
		chk("so_oe deselected", 16'h0000, {15'h0, so_oe});
	endtask : xfer

	task automatic status(input logic [7:0] exp);
		xfer({OP_STATUS_READ_CMD, 56'h0}, 24, 12);
		chk("status twice", {exp, exp}, rx[15:0]);
		chk("so_oe paused", 16'h0000, {15'h0, hold_oe});
	endtask : status

	task automatic mem_rd(input logic [15:0] a, input logic [15:0] exp);
		xfer({OP_READ, a, 40'h0}, 40);
		chk("read data", exp, rx[15:0]);
		chk("read oe", 16'h0001, {15'h0, oe_seen});
	endtask : mem_rd

	task automatic write_enable_cmd();
		xfer({OP_WRITE_ENABLE_CMD, 56'h0}, 8);
	endtask : write_enable_cmd

	// ------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------
	initial begin
		#200000;
		failures++;
		test_done();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		failures = 0;
		compares = 0;
		mode3 = 1'b0;
		rst_n = 1'b0;
		wp_n = 1'b1;
		repeat (10) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		repeat (8) @(posedge core_clk);
		status(8'h00);
		mem_rd(16'h0005, 16'hffff);
		xfer({OP_WRITE, 16'h0040, 8'h12, 32'h0}, 32);
		mem_rd(16'h0040, 16'hffff);
		xfer({OP_WRITE_ENABLE_CMD, 56'h0}, 9);
		status(8'h00);
		write_enable_cmd();
		status(8'h02);
		xfer({OP_WRITE_DISABLE_CMD, 56'h0}, 8);
		status(8'h00);
		write_enable_cmd();
		xfer({OP_WRITE, 16'hf010, 16'ha55a, 24'h0}, 40);
		status(8'h03);
		xfer({OP_READ, 16'h0010, 40'h0}, 40);
		chk("busy read oe", 16'h0000, {15'h0, oe_seen});
		repeat (500) @(posedge core_clk);
		status(8'h00);
		mem_rd(16'h0010, 16'ha55a);
		xfer({8'h07, 56'hffffffffffffff}, 24);
		chk("unknown oe", 16'h0000, {15'h0, oe_seen});
		write_enable_cmd();
		xfer({OP_STATUS_WRITE_CMD, 8'hff, 48'h0}, 16);
		repeat (500) @(posedge core_clk);
		status(8'h8c);
		@(posedge core_clk);
		#1;
		wp_n = 1'b0;
		write_enable_cmd();
		xfer({OP_STATUS_WRITE_CMD, 8'h00, 48'h0}, 16);
		repeat (500) @(posedge core_clk);
		status(8'h8e);
		xfer({OP_WRITE, 16'h0020, 8'h00, 32'h0}, 32);
		repeat (500) @(posedge core_clk);
		mem_rd(16'h0020, 16'hffff);
		test_done();
	end
endmodule : spi_eeprom_command_status_logic_tb_top

`default_nettype wire
